// ==== retrot_map.svh ====
// Purpose: Named constants for the return and rotate execution block
// Assumes: Included by bare name wherever the block needs them
// Notes:   Definitions only
`ifndef RETROT_MAP_SVH
`define RETROT_MAP_SVH

// ***************************************
// Opcode patterns
// ***************************************
`define OP_RET_MASK   16'hfffe
`define OP_RET_CODE   16'h0012
`define OP_ROT_MASK   16'hfc00
`define OP_ROT_CODE   16'h3400
`define FAST_BIT      0
`define DEST_BIT      9
`define BANK_BIT      8

// ***************************************
// Status register fields
// ***************************************
`define ST_CARRY      0
`define ST_ZERO       2
`define ST_NEG        4

// ***************************************
// Data memory banking
// ***************************************
`define ACC_SPLIT     8'h80
`define ACC_LO_BANK   4'h0
`define ACC_HI_BANK   4'hf
`define PC_STEP       21'h000002

// ***************************************
// Software register offsets
// ***************************************
`define REG_WORK      4'h0
`define REG_STATUS    4'h1
`define REG_BANK      4'h2
`define REG_WSHAD     4'h3
`define REG_SSHAD     4'h4
`define REG_BSHAD     4'h5
`define REG_PCL       4'h6
`define REG_PCH       4'h7
`define REG_PCU       4'h8
`define REG_PC_HIGH_LATCH    4'h9
`define REG_PC_UPPER_LATCH    4'ha
`define REG_EXEC      4'hb

// ***************************************
// Reset values
// ***************************************
`define RST_BYTE      8'h00
`define RST_PC        21'h000000
`define RST_INSTR     16'h0000

`endif

// ==== retrot_pkg.sv ====
// Purpose: Types shared by the return and rotate execution block
// Assumes: Nothing beyond the map header
// Notes:   One-hot codes are written out
package retrot_pkg;

    // Quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } phase_t;

    // Which instruction occupies the current cycle
    typedef enum logic [2:0] {
        EX_IDLE = 3'h1,
        EX_RET  = 3'h2,
        EX_ROT  = 3'h4
    } exec_t;

    // Data memory request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        we;
    } fileReq_t;

endpackage : retrot_pkg

// ==== return_rotate_exec.sv ====
// Purpose: Executes subroutine return and rotate left through carry
// Assumes: Four clocks per instruction cycle, data memory reads combinationally
// Notes:   Other opcodes only advance the program counter
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "retrot_map.svh"

// What this block does
// - Decode return opcode, two cycles, second idle
// - Return pops stack top into program counter
// - Fast selector set restores all three shadows
// - Fast selector clear leaves registers untouched
// - Return keeps PC latches; only plain return keeps flags
// - Rotate left through carry, update C N Z
// - Destination bit picks working or file
// - Bank bit picks access bank or bank register
module return_rotate_exec
    import retrot_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] instrWord,
    output logic             instrTake,
    output logic [20:0]      pc,
    input  wire logic [20:0] stackTop,
    output logic             stackPop,
    output fileReq_t         fileReq,
    input  wire logic [7:0]  fileRdData,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [7:0]       regRdData
);

    // ***************************************
    // State
    // ***************************************
    phase_t      phase_r;
    exec_t       exec_r;
    logic        stall_r;
    logic [15:0] instr_r;
    logic [7:0]  working_r;
    logic [7:0]  status_r;
    logic [7:0]  bankSel_r;
    logic [7:0]  wShadow_r;
    logic [7:0]  sShadow_r;
    logic [7:0]  bShadow_r;
    logic [7:0]  pcHighLatch_r;
    logic [7:0]  pcUpperLatch_r;
    logic [20:0] pc_r;
    logic [7:0]  operand_r;
    logic [7:0]  result_r;
    fileReq_t    fileReq_r;
    logic [7:0]  regRdData_r;

    // ***************************************
    // Decode
    // ***************************************
    logic        isRet;
    logic        isRot;
    exec_t       exec_nxt;
    logic        retQ4;
    logic        rotQ4;
    logic        fastSel;
    logic        destFile;
    logic        bankByReg;
    logic [7:0]  fOffset;
    logic [3:0]  accBank;
    logic [3:0]  takeBank;
    logic [11:0] operandAddr;
    logic [7:0]  rotValue;
    logic        rotCarry;

    // Opcode match on the incoming word
    assign isRet     = (instrWord & `OP_RET_MASK) == `OP_RET_CODE;
    assign isRot     = (instrWord & `OP_ROT_MASK) == `OP_ROT_CODE;
    assign instrTake = (phase_r == PH_Q1) && !stall_r;
    assign exec_nxt  = !instrTake ? EX_IDLE : isRet ? EX_RET : isRot ? EX_ROT : EX_IDLE;

    // Fields of the latched word
    assign fastSel   = instr_r[`FAST_BIT];
    assign destFile  = instr_r[`DEST_BIT];
    assign bankByReg = instr_r[`BANK_BIT];
    assign fOffset   = instr_r[7:0];

    // Access bank splits into low and high halves
    // The operand address comes from the incoming word, so that it stands with the Q2 read
    assign accBank     = (fOffset < `ACC_SPLIT) ? `ACC_LO_BANK : `ACC_HI_BANK;
    assign takeBank    = (instrWord[7:0] < `ACC_SPLIT) ? `ACC_LO_BANK : `ACC_HI_BANK;
    assign operandAddr = instrWord[`BANK_BIT] ? {bankSel_r[3:0], instrWord[7:0]} : {takeBank, instrWord[7:0]};

    // Rotate through carry
    assign rotValue = {operand_r[6:0], status_r[`ST_CARRY]};
    assign rotCarry = operand_r[7];

    // Commit strobes in the last quarter
    assign retQ4    = (exec_r == EX_RET) && (phase_r == PH_Q4);
    assign rotQ4    = (exec_r == EX_ROT) && (phase_r == PH_Q4);
    assign stackPop = retQ4;

    // ***************************************
    // Phase and instruction sequencing
    // ***************************************

    // Quarter phase counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            phase_r <= PH_Q1;
        else
        begin
            case (phase_r)
                PH_Q1:   phase_r <= PH_Q2;
                PH_Q2:   phase_r <= PH_Q3;
                PH_Q3:   phase_r <= PH_Q4;
                PH_Q4:   phase_r <= PH_Q1;
                default: phase_r <= PH_Q1;
            endcase
        end
    end

    // Latch instruction in Q1; a return idles the next cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            exec_r  <= EX_IDLE;
            instr_r <= `RST_INSTR;
            stall_r <= 1'b0;
        end
        else
        begin
            if (phase_r == PH_Q1)
            begin
                exec_r  <= exec_nxt;
                instr_r <= instrWord;
            end
            if (retQ4)
                stall_r <= 1'b1;
            else if (phase_r == PH_Q4)
                stall_r <= 1'b0;
        end
    end

    // ***************************************
    // Data memory access for rotate
    // ***************************************

    // Read in Q2, compute in Q3, write in Q4
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fileReq_r <= '0;
            operand_r <= `RST_BYTE;
            result_r  <= `RST_BYTE;
        end
        else
        begin
            fileReq_r.rd <= (phase_r == PH_Q1) && (exec_nxt == EX_ROT);
            fileReq_r.we <= (exec_r == EX_ROT) && (phase_r == PH_Q3) && destFile;
            if ((phase_r == PH_Q1) && (exec_nxt == EX_ROT))
                fileReq_r.addr <= operandAddr;
            if (exec_r == EX_ROT && phase_r == PH_Q2)
                operand_r <= fileRdData;
            if (exec_r == EX_ROT && phase_r == PH_Q3)
            begin
                result_r        <= rotValue;
                fileReq_r.wdata <= rotValue;
            end
        end
    end

    // ***************************************
    // Core registers
    // ***************************************

    // Working, status and bank select; the core wins over software
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            working_r <= `RST_BYTE;
            status_r  <= `RST_BYTE;
            bankSel_r <= `RST_BYTE;
        end
        else if (retQ4 && fastSel)
        begin
            working_r <= wShadow_r;
            status_r  <= sShadow_r;
            bankSel_r <= bShadow_r;
        end
        else if (rotQ4)
        begin
            if (!destFile)
                working_r <= result_r;
            status_r[`ST_CARRY] <= rotCarry;
            status_r[`ST_ZERO]  <= (result_r == `RST_BYTE);
            status_r[`ST_NEG]   <= result_r[7];
        end
        else if (regWr && !retQ4)
        begin
            // Plain return leaves these alone
            if (regAddr == `REG_WORK)
                working_r <= regWrData;
            if (regAddr == `REG_STATUS)
                status_r <= regWrData;
            if (regAddr == `REG_BANK)
                bankSel_r <= regWrData;
        end
    end

    // Shadows and PC latches change only from software
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wShadow_r      <= `RST_BYTE;
            sShadow_r      <= `RST_BYTE;
            bShadow_r      <= `RST_BYTE;
            pcHighLatch_r  <= `RST_BYTE;
            pcUpperLatch_r <= `RST_BYTE;
        end
        else if (regWr)
        begin
            if (regAddr == `REG_WSHAD)
                wShadow_r <= regWrData;
            if (regAddr == `REG_SSHAD)
                sShadow_r <= regWrData;
            if (regAddr == `REG_BSHAD)
                bShadow_r <= regWrData;
            if (regAddr == `REG_PC_HIGH_LATCH)
                pcHighLatch_r <= regWrData;
            if (regAddr == `REG_PC_UPPER_LATCH)
                pcUpperLatch_r <= regWrData;
        end
    end

    // Program counter: return loads stack top, holds in its idle second cycle, else step by one word
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pc_r <= `RST_PC;
        else if (retQ4)
            pc_r <= stackTop;
        else if (phase_r == PH_Q4 && !stall_r)
            pc_r <= pc_r + `PC_STEP;
    end

    // ***************************************
    // Register read port
    // ***************************************
    logic [7:0] rdMux;

    assign rdMux = (regAddr == `REG_WORK)   ? working_r :
                   (regAddr == `REG_STATUS) ? status_r :
                   (regAddr == `REG_BANK)   ? bankSel_r :
                   (regAddr == `REG_WSHAD)  ? wShadow_r :
                   (regAddr == `REG_SSHAD)  ? sShadow_r :
                   (regAddr == `REG_BSHAD)  ? bShadow_r :
                   (regAddr == `REG_PCL)    ? pc_r[7:0] :
                   (regAddr == `REG_PCH)    ? pc_r[15:8] :
                   (regAddr == `REG_PCU)    ? {3'h0, pc_r[20:16]} :
                   (regAddr == `REG_PC_HIGH_LATCH) ? pcHighLatch_r :
                   (regAddr == `REG_PC_UPPER_LATCH) ? pcUpperLatch_r :
                   (regAddr == `REG_EXEC)   ? {4'h0, stall_r, exec_r} : `RST_BYTE;

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regRdData_r <= `RST_BYTE;
        else
            regRdData_r <= regRd ? rdMux : `RST_BYTE;
    end

    assign pc        = pc_r;
    assign fileReq   = fileReq_r;
    assign regRdData = regRdData_r;

    // ***************************************
    // Checks
    // ***************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence retCommit;
        retQ4;
    endsequence

    sequence idleCycle;
        !instrTake [*4];
    endsequence

    sequence rotRead;
        (exec_r == EX_ROT) && (phase_r == PH_Q2);
    endsequence

    a_ret_idle_cycle: assert property (retCommit |=> idleCycle)
        else $error("return did not idle its second cycle");

    a_ret_load_pc: assert property (retCommit |=> pc == $past(stackTop))
        else $error("return did not load stack top");

    a_fast_restore: assert property (retQ4 && fastSel |=>
        working_r == $past(wShadow_r) && status_r == $past(sShadow_r) && bankSel_r == $past(bShadow_r))
        else $error("fast restore did not copy shadows");

    a_plain_ret_keep: assert property (retQ4 && !fastSel |=>
        $stable(working_r) && $stable(status_r) && $stable(bankSel_r))
        else $error("plain return changed core registers");

    a_ret_keep_latch: assert property (retQ4 && !regWr |=>
        $stable(pcHighLatch_r) && $stable(pcUpperLatch_r))
        else $error("return changed a pc latch");

    a_rot_result: assert property (rotRead ##1 1 |=>
        fileReq.wdata == {$past(operand_r[6:0]), $past(status_r[`ST_CARRY])})
        else $error("rotate value wrong");

    a_rot_carry_out: assert property (rotQ4 |=> status_r[`ST_CARRY] == $past(operand_r[7]))
        else $error("carry not taken from bit seven");

    a_rot_dest_work: assert property (rotQ4 && !destFile |=> working_r == $past(result_r) && !$past(fileReq.we))
        else $error("rotate to working misrouted");

    a_rot_dest_file: assert property (rotQ4 && destFile |-> fileReq.we && fileReq.wdata == result_r)
        else $error("rotate to file not written");

    a_access_bank: assert property ((rotRead and !bankByReg) |-> fileReq.addr[11:8] == accBank && fileReq.rd)
        else $error("access bank address wrong");

    a_rot_one_cycle: assert property (instrTake && isRot |=> ##2 rotQ4 ##1 (exec_r == EX_IDLE || instrTake))
        else $error("rotate did not finish in one cycle");

endmodule : return_rotate_exec

// ==== return_and_rotate_carry_exec_test.sv ====
// Purpose: Self-checking bench for the return and rotate execution block
// Assumes: Four clocks per instruction cycle, opcode zero runs as a plain step
// Notes:   The bench plays data memory, return stack and software port
`timescale 1ns/1ps
`include "retrot_map.svh"
module return_and_rotate_carry_exec_test
    import retrot_pkg::*;
;
    logic        clk;
    logic        rst;
    logic [15:0] instrWord;
    logic        instrTake;
    logic [20:0] pc;
    logic [20:0] stackTop;
    logic        stackPop;
    fileReq_t    fileReq;
    logic [7:0]  fileRdData;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData;
    logic        regWr;
    logic        regRd;
    logic [7:0]  regRdData;
    int          fails;
    int          total_checks;

    // Device under test
    return_rotate_exec i_dut (.clk(clk), .rst(rst), .instrWord(instrWord), .instrTake(instrTake), .pc(pc),
        .stackTop(stackTop), .stackPop(stackPop), .fileReq(fileReq), .fileRdData(fileRdData),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ***************************************
    // Shared tasks
    // ***************************************
    task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // Let n edges pass, then sample settled outputs
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic regW(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge clk);
        regWr     <= 1'b0;
    endtask : regW

    task automatic regR(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        chk("regRdData", regRdData, exp);
    endtask : regR

    // Offer a word until a Q1 takes it; returns settled in the second quarter
    task automatic runI(input logic [15:0] w);
        int i;
        @(posedge clk);
        instrWord <= w;
        #1;
        for (i = 0; i < 8 && instrTake !== 1'b1; i++)
            step(1);
        if (instrTake !== 1'b1)
        begin
            fails++;
            close_out();
        end
        @(posedge clk);
        instrWord <= 16'h0000;
        #1;
    endtask : runI

    // ***************************************
    // Scenarios
    // ***************************************
    task automatic rot(input logic d, input logic a, input logic [3:0] bank, input logic [7:0] f,
                       input logic [7:0] data, input logic cin);
        logic [7:0]  res;
        logic [11:0] adr;
        logic [20:0] pc0;
        res = {data[6:0], cin};
        adr = a ? {bank, f} : {(f < 8'h80) ? 4'h0 : 4'hf, f};
        regW(`REG_WORK, 8'h5a);
        regW(`REG_STATUS, {7'h0, cin});
        regW(`REG_BANK, {4'h0, bank});
        fileRdData <= data;
        runI({6'b001101, d, a, f});
        pc0 = pc;
        chk("fileReq.rd", fileReq.rd, 1);
        chk("fileReq.addr", fileReq.addr, adr);
        step(2);
        chk("fileReq.we", fileReq.we, d);
        if (d)
            chk("fileReq.wdata", fileReq.wdata, res);
        step(1);
        chk("pc", pc, pc0 + 21'h2);
        regR(`REG_WORK, d ? 8'h5a : res);
        regR(`REG_STATUS, {3'h0, res[7], 1'b0, res == 8'h00, 1'b0, data[7]});
        $display("Rotate test done d=%0b a=%0b", d, a);
    endtask : rot

    task automatic ret(input logic s);
        logic [20:0] top;
        top = s ? 21'h1abcd4 : 21'h02468a;
        regW(`REG_WORK, 8'ha5);
        regW(`REG_STATUS, 8'h0a);
        regW(`REG_BANK, 8'h0e);
        regW(`REG_WSHAD, 8'h3c);
        regW(`REG_SSHAD, 8'h15);
        regW(`REG_BSHAD, 8'h07);
        regW(`REG_PC_HIGH_LATCH, 8'h44);
        regW(`REG_PC_UPPER_LATCH, 8'h1b);
        stackTop <= top;
        runI(`OP_RET_CODE | {15'h0, s});
        step(2);
        chk("stackPop", stackPop, 1);
        step(1);
        chk("pc", pc, top);
        chk("stackPop", stackPop, 0);
        chk("instrTake", instrTake, 0);
        step(4);
        chk("instrTake", instrTake, 1);
        regR(`REG_WORK, s ? 8'h3c : 8'ha5);
        regR(`REG_STATUS, s ? 8'h15 : 8'h0a);
        regR(`REG_BANK, s ? 8'h07 : 8'h0e);
        regR(`REG_PC_HIGH_LATCH, 8'h44);
        regR(`REG_PC_UPPER_LATCH, 8'h1b);
        $display("Return test done s=%0b", s);
    endtask : ret

    // ***************************************
    // Main sequence
    // ***************************************
    initial
    begin
        rst          = 1'b1;
        instrWord    = 16'h0000;
        stackTop     = 21'h000000;
        fileRdData   = 8'h00;
        regAddr      = 4'h0;
        regWrData    = 8'h00;
        regWr        = 1'b0;
        regRd        = 1'b0;
        fails        = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        #1;
        chk("pc", pc, 0);
        chk("fileReq", fileReq, 0);
        chk("instrTake", instrTake, 1);
        @(posedge clk);
        rst <= 1'b0;
        regR(`REG_STATUS, 8'h00);
        regR(4'hc, 8'h00);
        $display("Reset test done");
        rot(1'b0, 1'b0, 4'h0, 8'h12, 8'he6, 1'b0);
        rot(1'b1, 1'b1, 4'h3, 8'h90, 8'h80, 1'b0);
        rot(1'b1, 1'b0, 4'h0, 8'h85, 8'h01, 1'b1);
        rot(1'b0, 1'b1, 4'h5, 8'h40, 8'h7f, 1'b1);
        ret(1'b0);
        ret(1'b1);
        close_out();
    end
endmodule : return_and_rotate_carry_exec_test
